// ===== logic/mup_regs.svh
`ifndef MUP_REGS_SVH
`define MUP_REGS_SVH

// Relative ports inside the eight-port block.
`define MUP_PORT_TX_IRQ     3'h4
`define MUP_PORT_RX_IRQ     3'h5
`define MUP_PORT_UNUSED     3'h6
`define MUP_PORT_CHAN_SEL   3'h7

// Channel select field layout.
`define MUP_SEL_WIDTH       5
`define MUP_SEL_LOCAL_LSB   0
`define MUP_SEL_HALF_BIT    2
`define MUP_SEL_GROUP_LSB   3

// Reset values.
`define MUP_SEL_RESET       5'h00
`define MUP_MASK_RESET      4'h0

// Wait state counts chosen by the jumpers.
`define MUP_WAIT_NONE       2'h0
`define MUP_WAIT_ONE        2'h1
`define MUP_WAIT_TWO        2'h2
`define MUP_WAIT_THREE      2'h3

// Physical channels 1 to 3 are serial; channel 0 is the parallel pair; only serial channels have the shift-empty source.
`define MUP_SERIAL_MASK     4'he

`endif

// ===== logic/mup_pkg.sv
`default_nettype none
package mup_pkg;

   // Host bus pins as seen by the board.
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       sinp;
      logic       sout;
      logic       dbin;
      logic       wr_n;
   } mup_bus_t;

   // Switch and jumper straps; a switch that is off reads as one.
   typedef struct packed {
      logic [5:0] addr_sw_off;
      logic [1:0] group_sw_off;
      logic       half_sw_off;
      logic       nibble_steer_switch;
      logic       channel_swap_jumper;
      logic       one_wait_jumper;
      logic       two_wait_jumper;
      logic       three_wait_jumper;
      logic [3:0] emt_to_tx;
      logic [3:0] emt_to_rx;
   } mup_straps_t;

   // Interrupt sources, indexed by physical channel.
   typedef struct packed {
      logic [3:0] tx_holding_free;
      logic [3:0] rx_holding_full;
      logic [3:0] shift_empty_or_line_change;
   } mup_src_t;

   // Request to the local channel register logic.
   typedef struct packed {
      logic       start;
      logic       we;
      logic [3:0] sel;
      logic [1:0] reg_idx;
      logic [7:0] wdata;
   } mup_chan_req_t;

endpackage : mup_pkg
`default_nettype wire

// ===== logic/mup_sync.sv
`timescale 1ns/10ps
`default_nettype none
module mup_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rstn,
   // Data
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta;

   // The first stage feeds only the second one.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule : mup_sync
`default_nettype wire

// ===== logic/mup_irq_group.sv
`timescale 1ns/10ps
`default_nettype none
`include "mup_regs.svh"
module mup_irq_group (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rstn,
   // Sources and mask write
   input  wire logic [3:0] src,
   input  wire logic       mask_we,
   input  wire logic [3:0] mask_wdata,
   // Results
   output logic      [3:0] status,
   output logic      [3:0] mask,
   output logic      [3:0] req_oe
);
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mask <= `MUP_MASK_RESET; // RL22
      end else if (mask_we) begin
         mask <= mask_wdata;
      end
   end

   // Status shows the source whether or not it is masked.
   assign status = src; // RL19

   // Open-collector drive: enable pulls the line low while active and unmasked.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         req_oe <= '0;
      end else begin
         req_oe <= src & mask; // RL18
      end
   end

   a_masked_quiet: assert property (@(posedge mclk) disable iff (!rstn) // RL18
      (mask == 4'h0) && !mask_we |=> (req_oe == 4'h0))
      else $error("request driven while mask is clear");
   a_reset_mask: assert property (@(posedge mclk) $rose(rstn) |-> (mask == 4'h0)) // RL22
      else $error("mask not clear after reset");
endmodule : mup_irq_group
`default_nettype wire

// ===== logic/mup_port_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "mup_regs.svh"
// Overview of operation
// RL1 - Six switches place an eight-port block.
// RL2 - Example switch setting decodes ports 10h-17h.
// RL3 - Channel select at relative port 7, write-only.
// RL4 - Five-bit select picks one of 32 users.
// RL5 - Bits: local channel, half, group; rest ignored.
// RL6 - Group bits must equal group switches.
// RL7 - Half bit must equal half switch.
// RL8 - Switch on means select bit zero.
// RL9 - User number is local plus offset.
// RL10 - Local 0 parallel, 1-3 serial channels.
// RL11 - Swap jumper exchanges local channels 0, 2.
// RL12 - Interrupt nibble steered low or high.
// RL13 - Channel registers get zero to three waits.
// RL14 - Select and interrupt ports never wait.
// RL15 - Eight interrupt sources, transmit and receive.
// RL16 - Transmit request while holding register free.
// RL17 - Receive request while data is waiting.
// RL18 - Requests open-collector and individually maskable.
// RL19 - Status shows live source state.
// RL20 - Shift-empty or line-change is third source.
// RL21 - Host reads channel status when sources shared.
// RL22 - Interrupts disabled after reset.
// RL23 - Port 4 transmit, port 5 receive.
// RL24 - Interrupt ports need select in board group.
// RL25 - Channel select clears to zero on reset.
// RL26 - Unselected board neither drives nor waits.
module mup_port_decode
   import mup_pkg::*;
(
   // Clock and reset
   input  wire logic          mclk,
   input  wire logic          rstn,
   // Host bus
   input  wire mup_bus_t      bus_pins,
   output logic      [7:0]    data_out,
   output logic      [1:0]    data_oe,
   output logic               rdy_out,
   output logic               rdy_oe,
   // Switches and jumpers
   input  wire mup_straps_t   straps,
   // Local channels
   input  wire mup_src_t      sources,
   input  wire logic [7:0]    chan_rdata,
   output mup_chan_req_t      chan_req,
   // Interrupt request pins
   output logic      [3:0]    tx_request_out,
   output logic      [3:0]    tx_request_oe,
   output logic      [3:0]    rx_request_out,
   output logic      [3:0]    rx_request_oe
);

   // Synchronised pins.
   mup_bus_t    bus;
   mup_straps_t sw;
   mup_src_t    src;

   mup_sync #(.WIDTH($bits(mup_bus_t))) u_sync_bus (
      .mclk (mclk),
      .rstn (rstn),
      .din  (bus_pins),
      .dout (bus)
   );

   mup_sync #(.WIDTH($bits(mup_straps_t))) u_sync_straps (
      .mclk (mclk),
      .rstn (rstn),
      .din  (straps),
      .dout (sw)
   );

   mup_sync #(.WIDTH($bits(mup_src_t))) u_sync_src (
      .mclk (mclk),
      .rstn (rstn),
      .din  (sources),
      .dout (src)
   );

   // State.
   logic [`MUP_SEL_WIDTH-1:0] channel_select;
   logic                      io_wr_q;
   logic                      io_rd_q;
   logic [1:0]                wait_cnt;

   // Bus cycle decode.
   wire       io_wr    = bus.sout & ~bus.wr_n;
   wire       io_rd    = bus.sinp & bus.dbin;
   wire       wr_start = io_wr & ~io_wr_q;
   wire       rd_start = io_rd & ~io_rd_q;
   wire [2:0] rel_port = bus.addr[2:0];

   // Position 4 is the disable switch; positions 5 to 9 give address bits 7 to 3.
   wire board_en  = sw.addr_sw_off[5];                                   // RL1
   wire block_hit = board_en & (bus.addr[7:3] == sw.addr_sw_off[4:0]); // RL1 RL2

   // A switch that is on reads zero, so the expected bit is the off level.
   wire [1:0] sel_group = channel_select[`MUP_SEL_GROUP_LSB +: 2];       // RL5
   wire       sel_half  = channel_select[`MUP_SEL_HALF_BIT];             // RL5
   wire [1:0] sel_local = channel_select[`MUP_SEL_LOCAL_LSB +: 2];       // RL5
   wire       group_hit = (sel_group == sw.group_sw_off);                // RL6 RL8
   wire       half_hit  = (sel_half == sw.half_sw_off);                  // RL7 RL8
   wire       board_sel = group_hit & half_hit;                          // RL9

   // Port classes.
   wire chan_port = block_hit & ~rel_port[2];
   wire tx_port   = block_hit & (rel_port == `MUP_PORT_TX_IRQ);
   wire rx_port   = block_hit & (rel_port == `MUP_PORT_RX_IRQ);
   wire sel_port  = block_hit & (rel_port == `MUP_PORT_CHAN_SEL);
   wire irq_ok    = group_hit;                                           // RL24

   // Channel register accesses reach the local channel only when this board is selected.
   wire chan_hit   = chan_port & board_sel;                              // RL26
   wire chan_start = chan_hit & (wr_start | rd_start);

   // Swap jumper exchanges local 0 and 2; physical 0 is the parallel pair.
   wire [1:0] phys_chan = (sw.channel_swap_jumper & ~sel_local[0]) ?
                          (sel_local ^ 2'h2) : sel_local;                // RL10 RL11
   wire [3:0] phys_onehot = 4'h1 << phys_chan;

   // Wait count: jumpers are meant to be exclusive; the largest wins if not.
   wire [1:0] wait_n = sw.three_wait_jumper ? `MUP_WAIT_THREE :
                       sw.two_wait_jumper   ? `MUP_WAIT_TWO   :
                       sw.one_wait_jumper   ? `MUP_WAIT_ONE   :
                                              `MUP_WAIT_NONE;           // RL13

   // Interrupt sources per physical channel, then mapped to local order.
   wire [3:0] emt      = src.shift_empty_or_line_change & `MUP_SERIAL_MASK;    // RL20
   wire [3:0] tx_phys  = src.tx_holding_free | (emt & sw.emt_to_tx);     // RL15 RL16
   wire [3:0] rx_phys  = src.rx_holding_full | (emt & sw.emt_to_rx);     // RL15 RL17
   wire [3:0] tx_local = sw.channel_swap_jumper ?
                         {tx_phys[3], tx_phys[0], tx_phys[1], tx_phys[2]} : tx_phys; // RL11
   wire [3:0] rx_local = sw.channel_swap_jumper ?
                         {rx_phys[3], rx_phys[0], rx_phys[1], rx_phys[2]} : rx_phys; // RL11

   // Interrupt masks take the nibble that this board is steered to.
   wire [3:0] wr_nibble = sw.nibble_steer_switch ? bus.wdata[7:4] : bus.wdata[3:0]; // RL12
   wire       tx_mask_we = tx_port & irq_ok & wr_start;                 // RL23 RL24
   wire       rx_mask_we = rx_port & irq_ok & wr_start;                 // RL23 RL24
   wire [3:0] tx_status;
   wire [3:0] rx_status;
   wire [3:0] tx_mask;
   wire [3:0] rx_mask;
   wire [3:0] tx_oe_int;
   wire [3:0] rx_oe_int;

   mup_irq_group u_tx_irq (
      .mclk       (mclk),
      .rstn       (rstn),
      .src        (tx_local),
      .mask_we    (tx_mask_we),
      .mask_wdata (wr_nibble),
      .status     (tx_status),
      .mask       (tx_mask),
      .req_oe     (tx_oe_int)
   );

   mup_irq_group u_rx_irq (
      .mclk       (mclk),
      .rstn       (rstn),
      .src        (rx_local),
      .mask_we    (rx_mask_we),
      .mask_wdata (wr_nibble),
      .status     (rx_status),
      .mask       (rx_mask),
      .req_oe     (rx_oe_int)
   );

   // Open-collector requests only ever pull low.
   assign tx_request_out = 4'h0; // RL18
   assign tx_request_oe  = tx_oe_int;
   assign rx_request_out = 4'h0; // RL18
   assign rx_request_oe  = rx_oe_int;

   // Read data: the status nibble goes on one half only, so the other half floats high.
   wire       irq_rd     = io_rd & (tx_port | rx_port) & irq_ok;         // RL24
   wire [3:0] rd_status  = tx_port ? tx_status : rx_status;              // RL19 RL23
   wire [7:0] irq_byte   = sw.nibble_steer_switch ? {rd_status, 4'h0} : {4'h0, rd_status};
   wire [1:0] irq_oe     = sw.nibble_steer_switch ? 2'h2 : 2'h1;         // RL12
   wire       chan_rd    = io_rd & chan_hit;                             // RL26

   logic [7:0] next_data_out;
   logic [1:0] next_data_oe;

   // Port 7 is never read back and port 6 never answers.
   always_comb begin
      next_data_out = 8'h00;
      next_data_oe  = 2'h0;
      if (chan_rd) begin
         next_data_out = chan_rdata;
         next_data_oe  = 2'h3;
      end else if (irq_rd) begin
         next_data_out = irq_byte;
         next_data_oe  = irq_oe;                                          // RL12
      end
   end

   // Channel select is shared by every board on the block, so every board latches it.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         channel_select <= `MUP_SEL_RESET;                                // RL25
      end else if (sel_port & wr_start) begin
         channel_select <= bus.wdata[`MUP_SEL_WIDTH-1:0];                 // RL3 RL4 RL5
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         io_wr_q <= 1'b0;
         io_rd_q <= 1'b0;
      end else begin
         io_wr_q <= io_wr;
         io_rd_q <= io_rd;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         data_out <= 8'h00;
         data_oe  <= 2'h0;
      end else begin
         data_out <= next_data_out;
         data_oe  <= next_data_oe;
      end
   end

   // Only channel register accesses load the wait counter.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wait_cnt <= 2'h0;
      end else if (chan_start) begin
         wait_cnt <= wait_n;                                              // RL13 RL14
      end else if (wait_cnt != 2'h0) begin
         wait_cnt <= wait_cnt - 2'h1;
      end
   end

   // The ready line is open collector: pulled low while waits remain.
   assign rdy_out = 1'b0;
   assign rdy_oe  = (wait_cnt != 2'h0);                                   // RL13

   // Channel request carries the physical channel after the swap.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         chan_req <= '0;
      end else begin
         chan_req.start   <= chan_start;
         chan_req.we      <= wr_start;
         chan_req.sel     <= chan_hit ? phys_onehot : 4'h0;               // RL10 RL11
         chan_req.reg_idx <= rel_port[1:0];
         chan_req.wdata   <= bus.wdata;
      end
   end

   // Checks.
   a_sel_reset: assert property (@(posedge mclk) $rose(rstn) |-> (channel_select == 5'h00)) // RL25
      else $error("channel select not clear after reset");

   a_sel_write: assert property (@(posedge mclk) disable iff (!rstn) // RL3
      sel_port && wr_start |=> (channel_select == $past(bus.wdata[4:0])))
      else $error("channel select did not take written value");

   a_block_miss: assert property (@(posedge mclk) disable iff (!rstn) // RL1
      wr_start && !block_hit |=> $stable(channel_select))
      else $error("write outside the block changed channel select");

   a_unsel_quiet: assert property (@(posedge mclk) disable iff (!rstn) // RL26
      io_rd && chan_port && !board_sel |=> (data_oe == 2'h0) && !chan_req.start)
      else $error("unselected board answered a channel read");

   a_wait_two: assert property (@(posedge mclk) disable iff (!rstn) // RL13
      chan_start && (wait_n == 2'h2) |=> rdy_oe [*2] ##1 !rdy_oe)
      else $error("two wait states not inserted");

   a_fast_ports: assert property (@(posedge mclk) disable iff (!rstn) // RL14
      (wait_cnt == 2'h0) && !chan_start |=> !rdy_oe)
      else $error("wait inserted on a non-channel access");

   a_nibble_high: assert property (@(posedge mclk) disable iff (!rstn) // RL12
      irq_rd && !chan_rd && sw.nibble_steer_switch |=> (data_oe == 2'h2))
      else $error("status not on the high nibble");

   a_status_low: assert property (@(posedge mclk) disable iff (!rstn) // RL19
      irq_rd && tx_port && !sw.nibble_steer_switch |=>
      (data_out[3:0] == $past(tx_status)) && (data_oe == 2'h1))
      else $error("transmit status not on the low nibble");

   a_swap_map: assert property (@(posedge mclk) disable iff (!rstn) // RL11
      chan_start && sw.channel_swap_jumper && (sel_local == 2'h0) |=> (chan_req.sel == 4'h4))
      else $error("swap jumper did not map local 0 to the middle channel");

   a_group_gate: assert property (@(posedge mclk) disable iff (!rstn) // RL24
      (tx_port || rx_port) && !group_hit |-> !tx_mask_we && !rx_mask_we)
      else $error("mask written from outside the board group");

   a_chan_answer: assert property (@(posedge mclk) disable iff (!rstn) // RL10
      chan_rd |=> (data_oe == 2'h3) && (data_out == $past(chan_rdata)))
      else $error("channel read data not driven");

   a_sel_no_read: assert property (@(posedge mclk) disable iff (!rstn) // RL3
      io_rd && sel_port |=> (data_oe == 2'h0))
      else $error("channel select port was read back");

   a_irq_refused: assert property (@(posedge mclk) disable iff (!rstn) // RL24
      io_rd && (tx_port || rx_port) && !group_hit |=> (data_oe == 2'h0))
      else $error("status driven from outside the board group");

   a_wait_one: assert property (@(posedge mclk) disable iff (!rstn) // RL13
      chan_start && (wait_n == 2'h1) |=> rdy_oe ##1 !rdy_oe)
      else $error("one wait state not inserted");

   a_wait_three: assert property (@(posedge mclk) disable iff (!rstn) // RL13
      chan_start && (wait_n == 2'h3) |=> rdy_oe [*3] ##1 !rdy_oe)
      else $error("three wait states not inserted");

   a_wait_none: assert property (@(posedge mclk) disable iff (!rstn) // RL13
      chan_start && (wait_n == 2'h0) |=> !rdy_oe)
      else $error("wait inserted with no jumper fitted");

   a_local_three: assert property (@(posedge mclk) disable iff (!rstn) // RL10
      chan_start && (sel_local == 2'h3) |=> (chan_req.sel == 4'h8))
      else $error("local 3 did not reach the left channel");

   a_swap_back: assert property (@(posedge mclk) disable iff (!rstn) // RL11
      chan_start && sw.channel_swap_jumper && (sel_local == 2'h2) |=> (chan_req.sel == 4'h1))
      else $error("swap jumper did not map local 2 to the parallel pair");

   a_mask_high: assert property (@(posedge mclk) disable iff (!rstn) // RL12
      tx_mask_we && sw.nibble_steer_switch |=> (tx_mask == $past(bus.wdata[7:4])))
      else $error("transmit mask not taken from the high nibble");

   a_mask_low: assert property (@(posedge mclk) disable iff (!rstn) // RL12
      rx_mask_we && !sw.nibble_steer_switch |=> (rx_mask == $past(bus.wdata[3:0])))
      else $error("receive mask not taken from the low nibble");

   c_chan_wait:  cover property (@(posedge mclk) disable iff (!rstn) chan_start && (wait_n == 2'h3));
   c_sel_write:  cover property (@(posedge mclk) disable iff (!rstn) sel_port && wr_start);
   c_irq_read:   cover property (@(posedge mclk) disable iff (!rstn) irq_rd && (rd_status != 4'h0));
   c_swap_chan:  cover property (@(posedge mclk) disable iff (!rstn)
      chan_start && sw.channel_swap_jumper && (sel_local == 2'h2));
   c_unsel_read: cover property (@(posedge mclk) disable iff (!rstn)
      io_rd && chan_port && !board_sel);

endmodule : mup_port_decode
`default_nettype wire

// ===== testbench/mup_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module mup_host_model
   import mup_pkg::*;
(
   // Clock
   input  wire logic       mclk,
   // Host bus
   output var  mup_bus_t   bus_pins,
   input  wire logic [7:0] data_out,
   input  wire logic [1:0] data_oe,
   input  wire logic       rdy_oe
);
   initial bus_pins = '{addr: 8'hff, wdata: 8'hff, sinp: 1'b0, sout: 1'b0, dbin: 1'b0, wr_n: 1'b1};

   // Holds the strobe until any wait request has come and gone, then releases it.
   task automatic io_cycle(input logic [7:0] a, input logic wr, input logic [7:0] d,
                           output logic [7:0] rd, output int waits, output logic [1:0] oe);
      int n;
      @(negedge mclk);
      bus_pins <= '{addr: a, wdata: d, sinp: !wr, sout: wr, dbin: !wr, wr_n: !wr};
      waits = 0;
      // Outputs are looked at on the falling edge, where they have settled.
      for (n = 0; n < 12; n++) begin
         @(negedge mclk);
         if (rdy_oe === 1'b1) waits++;
         // Undriven nibbles read as ones because the bus lines are pulled up.
         rd = {data_oe[1] ? data_out[7:4] : 4'hf, data_oe[0] ? data_out[3:0] : 4'hf};
         oe = data_oe;
         if (n >= 5 && rdy_oe !== 1'b1) break;
      end
      if (n == 12) waits = -1;
      // Released lines do not keep their last value.
      @(negedge mclk);
      bus_pins <= '{addr: ~a, wdata: ~d, sinp: 1'b0, sout: 1'b0, dbin: 1'b0, wr_n: 1'b1};
      repeat (4) @(posedge mclk);
   endtask : io_cycle
endmodule : mup_host_model
`default_nettype wire

// ===== testbench/multiuser_port_select_decode_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module multiuser_port_select_decode_tb
   import mup_pkg::*;
   ;
   logic          mclk;
   logic          rstn;
   mup_bus_t      bus_pins;
   logic [7:0]    data_out;
   logic [1:0]    data_oe;
   logic          rdy_out;
   logic          rdy_oe;
   mup_straps_t   straps;
   mup_src_t      sources;
   logic [7:0]    chan_rdata;
   mup_chan_req_t chan_req;
   mup_chan_req_t last_req;
   logic [3:0]    tx_request_out;
   logic [3:0]    tx_request_oe;
   logic [3:0]    rx_request_out;
   logic [3:0]    rx_request_oe;
   logic [7:0]    rd;
   logic [1:0]    oe;
   logic [7:0]    sels [3];
   int            waits;
   int            starts;
   int            n0;
   int            phys;
   int            miscompares;
   int            compares;

   mup_port_decode u_mup_port_decode (.mclk(mclk), .rstn(rstn), .bus_pins(bus_pins),
      .data_out(data_out), .data_oe(data_oe), .rdy_out(rdy_out), .rdy_oe(rdy_oe),
      .straps(straps), .sources(sources), .chan_rdata(chan_rdata), .chan_req(chan_req),
      .tx_request_out(tx_request_out), .tx_request_oe(tx_request_oe),
      .rx_request_out(rx_request_out), .rx_request_oe(rx_request_oe));

   mup_host_model u_mup_host_model (.mclk(mclk), .bus_pins(bus_pins), .data_out(data_out),
      .data_oe(data_oe), .rdy_oe(rdy_oe));

   initial mclk = 1'b0;
   always #50 mclk = ~mclk;

   always @(negedge mclk) begin
      if (chan_req.start === 1'b1) begin
         starts++;
         last_req = chan_req;
      end
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_mup_host_model.io_cycle(a, 1'b1, d, rd, waits, oe);
      if (waits < 0) miscompares++;
   endtask : wr

   task automatic rdp(input logic [7:0] a);
      u_mup_host_model.io_cycle(a, 1'b0, 8'h00, rd, waits, oe);
      if (waits < 0) miscompares++;
   endtask : rdp

   task automatic stop_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test

   // A hang anywhere is cut short here and counted as a mismatch.
   initial begin
      #5000000;
      miscompares++;
      stop_test();
   end

   initial begin
      rstn = 1'b0;
      chan_rdata = 8'h3c;
      sources = '0;
      straps = '0;
      straps.addr_sw_off = 6'h22;
      straps.half_sw_off = 1'b1;
      straps.nibble_steer_switch = 1'b1;
      sels = '{8'h01, 8'h0d, 8'h15};
      repeat (10) @(posedge mclk);
      @(negedge mclk);
      rstn = 1'b1;
      sources.tx_holding_free = 4'hf;
      sources.rx_holding_full = 4'hf;
      repeat (6) @(posedge mclk);
      `CHK(tx_request_oe, 4'h0)
      `CHK(rx_request_oe, 4'h0)
      rdp(8'h10);
      `CHK(oe, 2'b00)
      `CHK(starts, 0)
      rdp(8'h14);
      `CHK(rd, 8'hff)
      for (int n = 0; n < 4; n++) begin
         @(negedge mclk);
         {straps.three_wait_jumper, straps.two_wait_jumper, straps.one_wait_jumper} =
            (n == 0) ? 3'b000 : 3'(1 << (n - 1));
         wr(8'h17, 8'h05);
         `CHK(waits, 0)
         rdp(8'h10);
         `CHK(waits, n)
         `CHK(rd, 8'h3c)
         `CHK({last_req.we, last_req.reg_idx, last_req.sel}, 7'h02)
         rdp(8'h14);
         `CHK(waits, 0)
      end
      for (int s = 0; s < 2; s++) begin
         for (int l = 0; l < 4; l++) begin
            @(negedge mclk);
            straps.channel_swap_jumper = s[0];
            wr(8'h17, 8'he4 | 8'(l));
            wr(8'h12, 8'h5a + 8'(l));
            phys = (s == 1 && l[0] == 1'b0) ? (l ^ 2) : l;
            `CHK(last_req.sel, 4'(1 << phys))
            `CHK(last_req.reg_idx, 2'h2)
            `CHK(last_req.we, 1'b1)
            `CHK(last_req.wdata, 8'h5a + 8'(l))
         end
      end
      @(negedge mclk);
      straps.channel_swap_jumper = 1'b0;
      foreach (sels[i]) begin
         wr(8'h17, sels[i]);
         n0 = starts;
         rdp(8'h10);
         `CHK(oe, 2'b00)
         `CHK(waits, 0)
         `CHK(starts, n0)
         rdp(8'h14);
         `CHK(oe, (i == 0) ? 2'b10 : 2'b00)
      end
      wr(8'h17, 8'h05);
      rdp(8'h18);
      `CHK(oe, 2'b00)
      rdp(8'h17);
      `CHK(oe, 2'b00)
      @(negedge mclk);
      straps.addr_sw_off = 6'h02;
      rdp(8'h10);
      `CHK(oe, 2'b00)
      @(negedge mclk);
      straps.addr_sw_off = 6'h27;
      rdp(8'h3a);
      `CHK(oe, 2'b11)
      rdp(8'h12);
      `CHK(oe, 2'b00)
      @(negedge mclk);
      straps.addr_sw_off = 6'h22;
      sources.tx_holding_free = 4'h6;
      sources.rx_holding_full = 4'h9;
      wr(8'h14, 8'hf0);
      `CHK(tx_request_oe, 4'h6)
      rdp(8'h14);
      `CHK(rd, 8'h6f)
      wr(8'h14, 8'h5f);
      `CHK(tx_request_oe, 4'h4)
      rdp(8'h15);
      `CHK(rd, 8'h9f)
      `CHK(rx_request_oe, 4'h0)
      wr(8'h15, 8'h80);
      `CHK(rx_request_oe, 4'h8)
      `CHK({tx_request_out, rx_request_out, rdy_out}, 9'h000)
      @(negedge mclk);
      sources = '{tx_holding_free: 4'h0, rx_holding_full: 4'h0, shift_empty_or_line_change: 4'h8};
      straps.emt_to_tx = 4'h8;
      wr(8'h14, 8'hf0);
      rdp(8'h14);
      `CHK(rd, 8'h8f)
      `CHK(tx_request_oe, 4'h8)
      @(negedge mclk);
      straps.half_sw_off = 1'b0;
      straps.nibble_steer_switch = 1'b0;
      wr(8'h17, 8'h01);
      rdp(8'h14);
      `CHK(rd, 8'hf8)
      `CHK(oe, 2'b01)
      @(negedge mclk);
      sources.rx_holding_full = 4'h6;
      wr(8'h15, 8'ha3);
      `CHK(rx_request_oe, 4'h2)
      // A second reset in mid-run must close the masks and clear the select again.
      @(negedge mclk);
      rstn = 1'b0;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      rstn = 1'b1;
      repeat (4) @(posedge mclk);
      `CHK(tx_request_oe, 4'h0)
      `CHK(rx_request_oe, 4'h0)
      rdp(8'h10);
      `CHK(last_req.sel, 4'h1)
      stop_test();
   end
endmodule : multiuser_port_select_decode_tb
`default_nettype wire
